// ===== inc/clbs_pkg.sv
// Constants and types shared by the local bus cycle sequencer.
package clbs_pkg;

  // ****************************************
  // Cycle type codes (bit2, bit1, bit0)
  // ****************************************
  localparam logic [2:0] CC_INTACK = 3'h0;
  localparam logic [2:0] CC_IO_RD = 3'h1;
  localparam logic [2:0] CC_IO_WR = 3'h2;
  localparam logic [2:0] CC_HALT = 3'h3;
  localparam logic [2:0] CC_FETCH = 3'h4;
  localparam logic [2:0] CC_MEM_RD = 3'h5;
  localparam logic [2:0] CC_MEM_WR = 3'h6;
  localparam logic [2:0] CC_PASSIVE = 3'h7;
  localparam int CC_MEM_BIT = 2;

  // ****************************************
  // Segment codes (high, low)
  // ****************************************
  localparam logic [1:0] SEG_EXTRA = 2'h0;
  localparam logic [1:0] SEG_STACK = 2'h1;
  localparam logic [1:0] SEG_CODE = 2'h2;
  localparam logic [1:0] SEG_DATA = 2'h3;

  // ****************************************
  // Status field positions on the upper pins
  // ****************************************
  localparam int ST_SEG_LO = 0;
  localparam int ST_SEG_HI = 1;
  localparam int ST_IE = 2;
  localparam int ST_ZERO = 3;
  localparam logic ST_SPARE_VAL = 1'b0;

  // ****************************************
  // Addresses, vectors and timing
  // ****************************************
  localparam logic [19:0] BOOT_ADDR = 20'hF_FFF0;
  localparam logic [7:0] NMI_TYPE = 8'h02;
  localparam int VEC_SHIFT = 2;
  localparam logic [3:0] IO_UPPER = 4'h0;
  localparam logic [2:0] INIT_CLOCKS = 3'h7;
  localparam logic [1:0] NMI_HOLD_CLOCKS = 2'h2;
  localparam int SYNC_W = 20;

  typedef enum logic [2:0] {
    ST_INIT, ST_IDLE, ST_T1, ST_T2, ST_T3, ST_TW, ST_T4
  } clbs_state_t;

endpackage : clbs_pkg

// ===== verilog/clbs_seq.sv
// Local bus cycle sequencer with reset entry and non-maskable interrupt latching.
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
module clbs_seq
  import clbs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Device pins
  input wire logic cpu_reset,
  input wire logic config_strap,
  input wire logic nmi_pin,
  input wire logic ready_pin,
  input wire logic [15:0] ad_i,
  output logic [15:0] ad_o,
  output logic ad_oe,
  output logic [3:0] addr_hi_o,
  output logic high_byte_enable_n,
  output logic ale_o,
  output logic [2:0] cycle_code_o,
  // Core request side
  input wire logic req,
  input wire logic [2:0] req_code,
  input wire logic [19:0] req_addr,
  input wire logic [1:0] req_seg,
  input wire logic req_word,
  input wire logic req_direct,
  input wire logic [15:0] req_wdata,
  input wire logic int_enable,
  output logic req_busy_o,
  output logic done_o,
  output logic [15:0] rdata_o,
  output logic boot_done_o,
  // Interrupt side
  input wire logic instr_end,
  input wire logic maskable_request,
  input wire logic int_return_instr,
  input wire logic [15:0] flags_word,
  input wire logic [15:0] code_seg,
  input wire logic [15:0] instr_pointer,
  output logic nmi_pending_o,
  output logic int_take_o,
  output logic maskable_request_grant_o,
  output logic [7:0] int_type_o,
  output logic [19:0] vec_addr_o,
  output logic restore_o,
  output logic [15:0] saved_flags_o,
  output logic [15:0] saved_cs_o,
  output logic [15:0] saved_ip_o
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic rst_s;
  logic strap_s;
  logic nmi_s;
  logic rdy_s;
  logic [15:0] ad_s;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {cpu_reset, config_strap, nmi_pin, ready_pin, ad_i};
      sync2_r <= sync1_r;
    end
  end

  assign {rst_s, strap_s, nmi_s, rdy_s, ad_s} = sync2_r;

  // ****************************************
  // Cycle sequencer
  // ****************************************
  clbs_state_t state_r;
  clbs_state_t state_nxt;
  logic [2:0] init_cnt_r;
  logic pend_r;
  logic [2:0] cyc_code_r;
  logic [19:0] cyc_addr_r;
  logic [1:0] cyc_seg_r;
  logic cyc_word_r;
  logic cyc_ie_r;
  logic [15:0] cyc_wdata_r;
  logic accept;
  logic is_io;
  logic cyc_wr;
  logic in_status;

  assign accept = req && !pend_r && boot_done_o && !rst_s;
  assign is_io = !req_code[CC_MEM_BIT];
  assign cyc_wr = (cyc_code_r == CC_IO_WR) || (cyc_code_r == CC_MEM_WR);

  always_comb begin
    state_nxt = state_r;
    if (rst_s) begin
      state_nxt = ST_INIT;
    end else begin
      unique case (state_r)
        ST_INIT: begin
          if (init_cnt_r == 3'h1) begin
            state_nxt = ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (pend_r) begin
            state_nxt = ST_T1;
          end
        end
        ST_T1: state_nxt = ST_T2;
        ST_T2: state_nxt = ST_T3;
        ST_T3, ST_TW: state_nxt = rdy_s ? ST_T4 : ST_TW;
        ST_T4: state_nxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_INIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      init_cnt_r <= INIT_CLOCKS;
      boot_done_o <= 1'b0;
    end else if (rst_s) begin
      init_cnt_r <= INIT_CLOCKS;
      boot_done_o <= 1'b0;
    end else if (state_r == ST_INIT) begin
      init_cnt_r <= init_cnt_r - 3'h1;
      boot_done_o <= (init_cnt_r == 3'h1);
    end
  end

  // The boot fetch is loaded as the init count expires, user requests after that.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend_r <= 1'b0;
      cyc_code_r <= CC_PASSIVE;
      cyc_addr_r <= '0;
      cyc_seg_r <= SEG_CODE;
      cyc_word_r <= 1'b0;
      cyc_ie_r <= 1'b0;
      cyc_wdata_r <= '0;
    end else if (rst_s) begin
      pend_r <= 1'b0;
    end else if (state_r == ST_INIT && init_cnt_r == 3'h1) begin
      pend_r <= 1'b1;
      cyc_code_r <= CC_FETCH;
      cyc_addr_r <= BOOT_ADDR;
      cyc_seg_r <= SEG_CODE;
      cyc_word_r <= 1'b1;
      cyc_ie_r <= 1'b0;
    end else if (accept) begin
      pend_r <= 1'b1;
      cyc_code_r <= req_code;
      cyc_seg_r <= req_seg;
      cyc_word_r <= req_word;
      cyc_ie_r <= int_enable;
      cyc_wdata_r <= req_wdata;
      if (is_io && req_direct) begin
        cyc_addr_r <= {12'h000, req_addr[7:0]};
      end else if (is_io) begin
        cyc_addr_r <= {IO_UPPER, req_addr[15:0]};
      end else begin
        cyc_addr_r <= req_addr;
      end
    end else if (state_r == ST_T4) begin
      pend_r <= 1'b0;
    end
  end

  assign req_busy_o = pend_r;

  // ****************************************
  // Pin drive, registered from the next phase
  // ****************************************
  assign in_status = (state_nxt == ST_T2) || (state_nxt == ST_T3) ||
                     (state_nxt == ST_TW) || (state_nxt == ST_T4);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ale_o <= 1'b0;
      cycle_code_o <= CC_PASSIVE;
      addr_hi_o <= '0;
      high_byte_enable_n <= 1'b1;
      ad_o <= '0;
      ad_oe <= 1'b0;
    end else begin
      ale_o <= (state_nxt == ST_T1) && strap_s;
      cycle_code_o <= (in_status && state_nxt != ST_T4) || state_nxt == ST_T1 ?
                      cyc_code_r : CC_PASSIVE;
      ad_oe <= (state_nxt == ST_T1) || (in_status && cyc_wr);
      if (state_nxt == ST_T1) begin
        addr_hi_o <= cyc_addr_r[19:16];
        high_byte_enable_n <= !(cyc_word_r || cyc_addr_r[0]);
        ad_o <= cyc_addr_r[15:0];
      end else if (in_status) begin
        addr_hi_o[ST_SEG_LO] <= cyc_seg_r[0];
        addr_hi_o[ST_SEG_HI] <= cyc_seg_r[1];
        addr_hi_o[ST_IE] <= cyc_ie_r;
        addr_hi_o[ST_ZERO] <= 1'b0;
        high_byte_enable_n <= ST_SPARE_VAL;
        ad_o <= cyc_addr_r[0] ?
                {cyc_wdata_r[7:0], 8'h00} : cyc_wdata_r;
      end else begin
        addr_hi_o <= '0;
        high_byte_enable_n <= 1'b1;
        ad_o <= '0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done_o <= 1'b0;
      rdata_o <= '0;
    end else begin
      done_o <= (state_r == ST_T4) && !rst_s;
      if (state_r == ST_T4 && !cyc_wr) begin
        if (cyc_addr_r[0]) begin
          rdata_o <= {8'h00, ad_s[15:8]};
        end else if (cyc_word_r) begin
          rdata_o <= ad_s;
        end else begin
          rdata_o <= {8'h00, ad_s[7:0]};
        end
      end
    end
  end

  // ****************************************
  // Non-maskable interrupt and vectoring
  // ****************************************
  logic nmi_d_r;
  logic [1:0] hold_cnt_r;
  logic nmi_arm_r;
  logic nmi_edge;
  logic take_nmi;

  assign nmi_edge = nmi_s && !nmi_d_r && nmi_arm_r;
  assign take_nmi = instr_end && nmi_pending_o && !rst_s;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nmi_d_r <= 1'b0;
      hold_cnt_r <= '0;
      nmi_arm_r <= 1'b0;
    end else begin
      nmi_d_r <= nmi_s;
      if (rst_s) begin
        hold_cnt_r <= '0;
        nmi_arm_r <= 1'b0;
      end else if (!nmi_arm_r) begin
        hold_cnt_r <= hold_cnt_r + 2'h1;
        nmi_arm_r <= (hold_cnt_r == NMI_HOLD_CLOCKS - 2'h1);
      end
    end
  end

  // A new edge in the cycle of service sets again, so it is not lost.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nmi_pending_o <= 1'b0;
    end else if (rst_s) begin
      nmi_pending_o <= 1'b0;
    end else if (nmi_edge) begin
      nmi_pending_o <= 1'b1;
    end else if (take_nmi) begin
      nmi_pending_o <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      int_take_o <= 1'b0;
      maskable_request_grant_o <= 1'b0;
      int_type_o <= '0;
      vec_addr_o <= '0;
      restore_o <= 1'b0;
      saved_flags_o <= '0;
      saved_cs_o <= '0;
      saved_ip_o <= '0;
    end else begin
      int_take_o <= take_nmi;
      maskable_request_grant_o <= instr_end && !nmi_pending_o && maskable_request &&
                      int_enable && !rst_s;
      restore_o <= int_return_instr && !rst_s;
      if (take_nmi) begin
        int_type_o <= NMI_TYPE;
        vec_addr_o <= {10'h000, NMI_TYPE, 2'h0};
        saved_flags_o <= flags_word;
        saved_cs_o <= code_seg;
        saved_ip_o <= instr_pointer;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  phase_order_a: assert property (state_r == ST_T1 |=> state_r == ST_T2 ##1 state_r == ST_T3)
    else $error("bus phases out of order");
  wait_insert_a: assert property (state_r == ST_T3 && !rdy_s && !rst_s |=> state_r == ST_TW)
    else $error("no wait state while not ready");
  ready_adv_a: assert property ((state_r == ST_T3 || state_r == ST_TW) && rdy_s && !rst_s
    |=> state_r == ST_T4 ##1 state_r == ST_IDLE)
    else $error("ready did not lead to T4");
  ale_pulse_a: assert property ($rose(ale_o) |-> state_r == ST_T1 ##1 !ale_o)
    else $error("latch strobe outside T1");
  idle_passive_a: assert property (state_r == ST_IDLE |-> cycle_code_o == CC_PASSIVE)
    else $error("cycle code active in idle");
  seg_status_a: assert property (state_r == ST_T2 |-> addr_hi_o[1:0] == cyc_seg_r
    && !addr_hi_o[ST_ZERO])
    else $error("segment status wrong in T2");
  io_upper_a: assert property (state_r == ST_T1 && !cyc_code_r[CC_MEM_BIT]
    |-> addr_hi_o == IO_UPPER)
    else $error("upper lines not zero in I/O cycle");
  boot_seq_a: assert property ($fell(rst_s) |-> (state_r == ST_INIT)[*7]
    ##1 (state_r == ST_IDLE && pend_r && cyc_addr_r == BOOT_ADDR))
    else $error("init sequence length or boot address wrong");
  reset_stop_a: assert property (rst_s |=> state_r == ST_INIT ##1 !ale_o)
    else $error("activity during reset");
  nmi_ignore_a: assert property (!nmi_arm_r && !nmi_pending_o |=> !nmi_pending_o)
    else $error("nmi latched during hold-off");
  nmi_latch_a: assert property (nmi_edge && !rst_s |=> nmi_pending_o)
    else $error("nmi edge not latched");
  nmi_prio_a: assert property (take_nmi |=> int_take_o && !maskable_request_grant_o
    && vec_addr_o == 20'h0_0008)
    else $error("nmi not taken first with type 2");

  wait_seen_c: cover property (state_r == ST_TW ##1 state_r == ST_T4);
  io_write_c: cover property (state_r == ST_T1 && cyc_code_r == CC_IO_WR);
  nmi_taken_c: cover property (nmi_edge ##[1:20] int_take_o);
  boot_done_c: cover property ($rose(boot_done_o));

endmodule : clbs_seq

// ===== testbench/clbs_mem_model.sv
// Memory and I/O model answering on the far side of the local bus.
`timescale 1ns/100ps
module clbs_mem_model
  import clbs_pkg::*;
(
  // Bus pins
  input wire logic clk,
  input wire logic [15:0] ad_o,
  input wire logic [3:0] addr_hi_o,
  input wire logic high_byte_enable_n,
  input wire logic ale_o,
  input wire logic [2:0] cycle_code_o,
  output logic ready_pin,
  output logic [15:0] ad_i,
  // Control and capture
  input wire logic [3:0] waits,
  output logic [19:0] cap_addr,
  output logic [2:0] cap_code,
  output logic cap_bhe_n,
  output logic [3:0] cap_stat,
  output logic [15:0] cap_wdata,
  output logic [1:0] ale_cnt
);
  logic [2:0] prev_r = CC_PASSIVE;
  logic [3:0] cnt_r = 4'hF;
  logic start;

  // A cycle starts in the T1 clock, when the code leaves passive.
  assign start = (cycle_code_o != CC_PASSIVE) && (prev_r == CC_PASSIVE);

  // A slow device withholds ready from T1 until its wait count has run.
  assign ready_pin = (waits == 4'h0) || (!start && cnt_r >= waits && cnt_r != 4'hF);

  // Read data sit on both lanes; once the count reaches 7 the lines toggle every clock.
  always @(posedge clk) begin
    prev_r <= cycle_code_o;
    ale_cnt <= ale_cnt + {1'b0, ale_o};
    ad_i <= (cnt_r < 4'h7) ? ad_i : ~ad_i;
    if (cnt_r != 4'hF) begin
      cnt_r <= cnt_r + 4'h1;
    end
    if (start) begin
      cap_addr <= {addr_hi_o, ad_o};
      cap_code <= cycle_code_o;
      cap_bhe_n <= high_byte_enable_n;
      cnt_r <= 4'h1;
      ale_cnt <= {1'b0, ale_o};
      ad_i <= ad_o ^ 16'h5AC3;
    end
    if (cnt_r == 4'h1) begin
      cap_stat <= addr_hi_o;
    end
    if (cycle_code_o == CC_PASSIVE && prev_r != CC_PASSIVE) begin
      cap_wdata <= ad_o;
    end
  end
endmodule : clbs_mem_model

// ===== testbench/test_cpu_local_bus_cycle_sequencer.sv
// Self-checking bench for the local bus cycle sequencer.
`timescale 1ns/100ps
module test_cpu_local_bus_cycle_sequencer;
  import clbs_pkg::*;
  localparam logic [2:0] TC [8] = '{CC_MEM_RD, CC_MEM_RD, CC_FETCH, CC_MEM_WR,
                                    CC_IO_RD, CC_IO_RD, CC_IO_WR, CC_MEM_RD};
  localparam logic [19:0] TA [8] = '{20'hA_1234, 20'h3_0005, 20'h4_0002, 20'h5_0010,
                                     20'hF_2345, 20'h0_AB67, 20'h7_0008, 20'h2_0003};
  localparam logic [7:0] WORD_SEL = 8'hCD;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cpu_reset = 1'b0;
  logic config_strap = 1'b1;
  logic nmi_pin = 1'b0;
  logic req = 1'b0;
  logic [2:0] req_code = CC_FETCH;
  logic [19:0] req_addr = 20'h0_0000;
  logic [1:0] req_seg = 2'h0;
  logic req_word = 1'b0;
  logic req_direct = 1'b0;
  logic [15:0] req_wdata = 16'h0000;
  logic int_enable = 1'b0;
  logic instr_end = 1'b0;
  logic maskable_request = 1'b0;
  logic int_return_instr = 1'b0;
  logic [15:0] flags_word = 16'h0000;
  logic [15:0] code_seg = 16'h0000;
  logic [15:0] instr_pointer = 16'h0000;
  logic [3:0] waits = 4'h0;
  logic ready_pin, ad_oe, high_byte_enable_n, ale_o, req_busy_o, done_o, boot_done_o;
  logic nmi_pending_o, int_take_o, maskable_request_grant_o, restore_o, cap_bhe_n;
  logic [15:0] ad_i, ad_o, rdata_o, saved_flags_o, saved_cs_o, saved_ip_o, cap_wdata;
  logic [3:0] addr_hi_o, cap_stat;
  logic [2:0] cycle_code_o, cap_code;
  logic [7:0] int_type_o;
  logic [19:0] vec_addr_o, cap_addr;
  logic [1:0] ale_cnt;
  int mismatches = 0;
  int compares = 0;

  clbs_seq dut (.clk(clk), .resetn(resetn), .cpu_reset(cpu_reset),
    .config_strap(config_strap), .nmi_pin(nmi_pin), .ready_pin(ready_pin), .ad_i(ad_i),
    .ad_o(ad_o), .ad_oe(ad_oe), .addr_hi_o(addr_hi_o), .high_byte_enable_n(high_byte_enable_n),
    .ale_o(ale_o), .cycle_code_o(cycle_code_o), .req(req), .req_code(req_code),
    .req_addr(req_addr), .req_seg(req_seg), .req_word(req_word), .req_direct(req_direct),
    .req_wdata(req_wdata), .int_enable(int_enable), .req_busy_o(req_busy_o),
    .done_o(done_o), .rdata_o(rdata_o), .boot_done_o(boot_done_o), .instr_end(instr_end),
    .maskable_request(maskable_request), .int_return_instr(int_return_instr),
    .flags_word(flags_word), .code_seg(code_seg), .instr_pointer(instr_pointer),
    .nmi_pending_o(nmi_pending_o), .int_take_o(int_take_o), .maskable_request_grant_o(maskable_request_grant_o),
    .int_type_o(int_type_o), .vec_addr_o(vec_addr_o), .restore_o(restore_o),
    .saved_flags_o(saved_flags_o), .saved_cs_o(saved_cs_o), .saved_ip_o(saved_ip_o));

  clbs_mem_model model (.clk(clk), .ad_o(ad_o), .addr_hi_o(addr_hi_o),
    .high_byte_enable_n(high_byte_enable_n), .ale_o(ale_o), .cycle_code_o(cycle_code_o),
    .ready_pin(ready_pin), .ad_i(ad_i), .waits(waits), .cap_addr(cap_addr),
    .cap_code(cap_code), .cap_bhe_n(cap_bhe_n), .cap_stat(cap_stat),
    .cap_wdata(cap_wdata), .ale_cnt(ale_cnt));

  // ****
  // Tasks
  // ****
  task automatic give_verdict();
    if (mismatches == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      cmp(1'b1, 1'b0);
      give_verdict();
    end
  endtask : tmo

  // Init must last its full count and end in a fetch from the boot address.
  task automatic boot_chk();
    int n;
    for (n = 0; n < 60 && boot_done_o !== 1'b1; n++) @(posedge clk);
    tmo(n, 60);
    cmp(n >= 7, 1'b1);
    for (n = 0; n < 60 && cap_addr !== BOOT_ADDR; n++) @(posedge clk);
    tmo(n, 60);
    cmp(cap_code, CC_FETCH);
  endtask : boot_chk

  task automatic run(input int i);
    logic [19:0] a;
    logic [19:0] ea;
    logic [15:0] pat;
    logic [3:0] wt;
    int n;
    a = TA[i];
    wt = (i == 2) ? 4'h3 : {3'h0, i == 7};
    ea = (i == 5) ? {12'h000, a[7:0]} : TC[i][CC_MEM_BIT] ? a : {4'h0, a[15:0]};
    pat = ea[15:0] ^ 16'h5AC3;
    for (n = 0; n < 50 && (req_busy_o !== 1'b0 || boot_done_o !== 1'b1); n++) @(posedge clk);
    tmo(n, 50);
    @(posedge clk);
    waits <= wt;
    req <= 1'b1;
    req_code <= TC[i];
    req_addr <= a;
    req_seg <= a[1:0];
    req_word <= WORD_SEL[i];
    req_direct <= (i == 5);
    req_wdata <= a[15:0] ^ 16'h1234;
    int_enable <= a[2];
    @(posedge clk);
    req <= 1'b0;
    n = 1;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (done_o !== 1'b1 && n < 40);
    tmo(n, 40);
    if (wt == 4'h0) cmp(n, 6);
    else cmp(n, 6 + wt);
    cmp(cap_code, TC[i]);
    cmp(cap_addr, ea);
    cmp(cap_bhe_n, !(WORD_SEL[i] | a[0]));
    cmp(cap_stat, {1'b0, a[2], a[1:0]});
    cmp(ale_cnt, config_strap);
    cmp({ad_oe, cycle_code_o}, {1'b0, CC_PASSIVE});
    if (TC[i] == CC_MEM_WR || TC[i] == CC_IO_WR) cmp(cap_wdata, a[15:0] ^ 16'h1234);
    else cmp(rdata_o, a[0] ? pat[15:8] : WORD_SEL[i] ? pat : pat[7:0]);
  endtask : run

  task automatic step_end();
    @(posedge clk);
    instr_end <= 1'b1;
    @(posedge clk);
    instr_end <= 1'b0;
    #1;
  endtask : step_end

  // ****
  // Sequence
  // ****
  initial begin
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    boot_chk();
    for (int i = 0; i < 8; i++) run(i);
    @(posedge clk);
    config_strap <= 1'b0;
    for (int i = 0; i < 8; i++) run(i);
    @(posedge clk);
    flags_word <= 16'h0A55;
    code_seg <= 16'h1357;
    instr_pointer <= 16'h2468;
    maskable_request <= 1'b1;
    int_enable <= 1'b1;
    nmi_pin <= 1'b1;
    repeat (5) @(posedge clk);
    nmi_pin <= 1'b0;
    #1 cmp(nmi_pending_o, 1'b1);
    step_end();
    cmp({int_take_o, maskable_request_grant_o, nmi_pending_o}, 3'h4);
    cmp(int_type_o, 8'h02);
    cmp(vec_addr_o, 20'h0_0008);
    cmp({saved_flags_o, saved_cs_o, saved_ip_o}, 48'h0A55_1357_2468);
    step_end();
    cmp({int_take_o, maskable_request_grant_o}, 2'h1);
    @(posedge clk);
    nmi_pin <= 1'b1;
    repeat (5) @(posedge clk);
    #1 cmp(nmi_pending_o, 1'b1);
    @(posedge clk);
    int_return_instr <= 1'b1;
    @(posedge clk);
    int_return_instr <= 1'b0;
    #1 cmp(restore_o, 1'b1);
    @(posedge clk);
    cpu_reset <= 1'b1;
    nmi_pin <= 1'b0;
    repeat (3) @(posedge clk);
    nmi_pin <= 1'b1;
    repeat (3) @(posedge clk);
    nmi_pin <= 1'b0;
    #1 cmp({boot_done_o, nmi_pending_o}, 2'h0);
    // A rising edge that arrives with the end of reset falls in the hold-off.
    @(posedge clk);
    cpu_reset <= 1'b0;
    nmi_pin <= 1'b1;
    boot_chk();
    cmp(nmi_pending_o, 1'b0);
    give_verdict();
  end
endmodule : test_cpu_local_bus_cycle_sequencer
